// >>> src/scdc_dev_end.sv
// device end: clock mode register, oscillators, divider and state sequencer
`default_nettype none
module scdc_dev_end #(
   parameter int MAIN_CYC = scdc_pkg::MAIN_OSC_CYC,
   parameter int SUB_CYC  = scdc_pkg::SUB_OSC_CYC
) (
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_i,
   // link to the core
   scdc_if.dev       bus,
   // oscillator and clock status
   output logic      main_osc_run_o,
   output logic      sub_active_o,
   output logic      sys_clk_o
);
   localparam int CW = $clog2(SUB_CYC > MAIN_CYC ? SUB_CYC : MAIN_CYC);

   logic [CW-1:0]                    main_cnt_ff;
   logic [CW-1:0]                    sub_cnt_ff;
   logic                             main_tick_ff;
   logic                             sub_tick_ff;
   logic [scdc_pkg::SCS_USED_W-1:0]  cfg_ff;
   logic                             main_run_ff;
   logic                             act_sub_ff;
   logic [scdc_pkg::DIV_SEL_W-1:0]   act_div_ff;
   scdc_pkg::scdc_state_t            state_ff;
   scdc_pkg::scdc_phase_t            phase_ff;
   logic                             phase_tick_ff;
   logic                             sys_clk_ff;
   logic [7:0]                       rdata_ff;
   logic                             src_tick;
   logic                             sys_tick;
   logic                             boundary;
   logic                             halted;
   logic                             sel_load;
   logic                             sel_change;
   logic                             new_sub;
   logic [scdc_pkg::DIV_SEL_W-1:0]   new_div;

   function automatic logic last_cyc(input logic [CW-1:0] cnt, input int cyc);
      last_cyc = (cnt == CW'(cyc - 1));
   endfunction

   function automatic scdc_pkg::scdc_state_t next_state(input scdc_pkg::scdc_state_t s);
      case (s)
         scdc_pkg::ST_S1: next_state = scdc_pkg::ST_S2;
         scdc_pkg::ST_S2: next_state = scdc_pkg::ST_S3;
         scdc_pkg::ST_S3: next_state = scdc_pkg::ST_S4;
         scdc_pkg::ST_S4: next_state = scdc_pkg::ST_S5;
         scdc_pkg::ST_S5: next_state = scdc_pkg::ST_S6;
         default:         next_state = scdc_pkg::ST_S1;
      endcase
   endfunction

   // main oscillator, held still while stopped
   always_ff @(posedge mclk_i)
   begin
      if (rst_i || !main_run_ff)
      begin
         main_cnt_ff  <= '0;
         main_tick_ff <= 1'b0;
      end
      else
      begin
         main_tick_ff <= last_cyc(main_cnt_ff, MAIN_CYC);
         main_cnt_ff  <= last_cyc(main_cnt_ff, MAIN_CYC) ? '0 : main_cnt_ff + 1'b1;
      end
   end

   // sub oscillator always runs
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         sub_cnt_ff  <= '0;
         sub_tick_ff <= 1'b0;
      end
      else
      begin
         sub_tick_ff <= last_cyc(sub_cnt_ff, SUB_CYC);
         sub_cnt_ff  <= last_cyc(sub_cnt_ff, SUB_CYC) ? '0 : sub_cnt_ff + 1'b1;
      end
   end

   // clock mode register, reserved bits are not stored
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         cfg_ff <= scdc_pkg::SCS_RESET[scdc_pkg::SCS_USED_W-1:0];
      else if (bus.sfr_wr && bus.sfr_addr == scdc_pkg::SCS_OFFSET)
         cfg_ff <= bus.sfr_wdata[scdc_pkg::SCS_USED_W-1:0];
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         main_run_ff <= 1'b1;
      else
         main_run_ff <= !cfg_ff[scdc_pkg::BIT_MAIN_STOP];
   end

   // read port, holes answer a fixed idle value
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         rdata_ff <= scdc_pkg::RDATA_IDLE;
      else if (bus.sfr_rd)
      begin
         case (bus.sfr_addr)
            scdc_pkg::SCS_OFFSET:  rdata_ff <= 8'(cfg_ff);
            scdc_pkg::STAT_OFFSET: rdata_ff <= {main_run_ff, act_sub_ff, act_div_ff, state_ff};
            default:               rdata_ff <= scdc_pkg::RDATA_IDLE;
         endcase
      end
      else
         rdata_ff <= scdc_pkg::RDATA_IDLE;
   end

   // a halted clock has no pulse in flight, so it may switch at once
   assign new_sub    = cfg_ff[scdc_pkg::BIT_SUB_SW];
   assign new_div    = cfg_ff[scdc_pkg::DIV_SEL_W-1:0];
   assign halted     = !act_sub_ff && !main_run_ff;
   assign boundary   = sys_tick && state_ff == scdc_pkg::ST_S6 && phase_ff == scdc_pkg::PH_2;
   assign sel_load   = boundary || halted;
   assign sel_change = sel_load && (new_sub != act_sub_ff || new_div != act_div_ff);

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         act_sub_ff <= 1'b0;
         act_div_ff <= '0;
      end
      else if (sel_load)
      begin
         act_sub_ff <= new_sub;
         act_div_ff <= new_div;
      end
   end

   assign src_tick = act_sub_ff ? sub_tick_ff : main_tick_ff;

   scdc_clk_div u_div (
      .mclk_i     (mclk_i),
      .rst_i      (rst_i),
      .src_tick_i (src_tick),
      .restart_i  (sel_change),
      .sel_i      (act_div_ff),
      .tick_o     (sys_tick)
   );

   // reset sits at the last half so the first tick opens state one
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         state_ff      <= scdc_pkg::ST_S6;
         phase_ff      <= scdc_pkg::PH_2;
         phase_tick_ff <= 1'b0;
         sys_clk_ff    <= 1'b0;
      end
      else if (sys_tick)
      begin
         phase_tick_ff <= 1'b1;
         if (phase_ff == scdc_pkg::PH_1)
         begin
            phase_ff   <= scdc_pkg::PH_2;
            sys_clk_ff <= 1'b0;
         end
         else
         begin
            phase_ff   <= scdc_pkg::PH_1;
            sys_clk_ff <= 1'b1;
            state_ff   <= next_state(state_ff);
         end
      end
      else
         phase_tick_ff <= 1'b0;
   end

   assign bus.sfr_rdata  = rdata_ff;
   assign bus.state      = state_ff;
   assign bus.phase      = phase_ff;
   assign bus.phase_tick = phase_tick_ff;
   assign main_osc_run_o = main_run_ff;
   assign sub_active_o   = act_sub_ff;
   assign sys_clk_o      = sys_clk_ff;
endmodule
`default_nettype wire

// >>> pkg/scdc_pkg.sv
// constants and types shared by both ends of the system clock control
`default_nettype none
package scdc_pkg;
   // clock rates in Hz
   localparam int         CLK_HZ      = 100000000;
   localparam int         MAIN_OSC_HZ = 7200000;
   localparam int         SUB_OSC_HZ  = 32768;
   // whole mclk cycles per oscillator period, rounded down
   localparam int         MAIN_OSC_CYC = CLK_HZ / MAIN_OSC_HZ;
   localparam int         SUB_OSC_CYC  = CLK_HZ / SUB_OSC_HZ;
   // register map
   localparam logic [7:0] SCS_OFFSET  = 8'h80;
   localparam logic [7:0] STAT_OFFSET = 8'h8e;
   localparam logic [7:0] SCS_RESET   = 8'h00;
   localparam logic [7:0] RSVD_MASK   = 8'he0;
   localparam logic [7:0] RDATA_IDLE  = 8'h00;
   // field layout of system_clock_select
   localparam int         SCS_USED_W    = 5;
   localparam int         BIT_MAIN_STOP = 4;
   localparam int         BIT_SUB_SW    = 3;
   localparam int         BIT_DIV_EN    = 2;
   localparam int         DIV_SEL_W     = 3;
   localparam int         DIV_CNT_W     = 4;
   // machine cycle sequence
   typedef enum logic [2:0] {ST_S1, ST_S2, ST_S3, ST_S4, ST_S5, ST_S6} scdc_state_t;
   typedef enum logic {PH_1, PH_2} scdc_phase_t;
endpackage
`default_nettype wire

// >>> pkg/scdc_if.sv
// link between the clock control end and the cpu core end
`default_nettype none
interface scdc_if;
   logic [7:0]            sfr_addr;
   logic [7:0]            sfr_wdata;
   logic                  sfr_wr;
   logic                  sfr_rd;
   logic [7:0]            sfr_rdata;
   scdc_pkg::scdc_state_t state;
   scdc_pkg::scdc_phase_t phase;
   logic                  phase_tick;

   modport dev (
      input  sfr_addr,
      input  sfr_wdata,
      input  sfr_wr,
      input  sfr_rd,
      output sfr_rdata,
      output state,
      output phase,
      output phase_tick
   );

   modport core (
      output sfr_addr,
      output sfr_wdata,
      output sfr_wr,
      output sfr_rd,
      input  sfr_rdata,
      input  state,
      input  phase,
      input  phase_tick
   );
endinterface
`default_nettype wire

// >>> src/scdc_clk_div.sv
// divider from the selected oscillator tick to the system clock tick
`default_nettype none
module scdc_clk_div (
   // clock and reset
   input  wire logic                           mclk_i,
   input  wire logic                           rst_i,
   // source and selection
   input  wire logic                           src_tick_i,
   input  wire logic                           restart_i,
   input  wire logic [scdc_pkg::DIV_SEL_W-1:0] sel_i,
   // divided tick
   output logic                                tick_o
);
   logic [scdc_pkg::DIV_CNT_W-1:0] cnt_ff;
   logic                           armed_ff;
   logic                           tick_ff;

   function automatic logic [scdc_pkg::DIV_CNT_W-1:0] last_count(input logic [scdc_pkg::DIV_SEL_W-1:0] sel);
      logic [scdc_pkg::DIV_CNT_W:0] lim;
      lim = (5'h02 << sel[1:0]) - 5'h01;
      if (!sel[scdc_pkg::BIT_DIV_EN])
         last_count = '0;
      else
         last_count = lim[scdc_pkg::DIV_CNT_W-1:0];
   endfunction

   // after a switch the first source tick only arms, so no period comes out short
   always_ff @(posedge mclk_i)
   begin
      if (rst_i || restart_i)
      begin
         cnt_ff   <= '0;
         armed_ff <= 1'b0;
         tick_ff  <= 1'b0;
      end
      else if (src_tick_i && !armed_ff)
      begin
         armed_ff <= 1'b1;
         tick_ff  <= 1'b0;
      end
      else if (src_tick_i)
      begin
         tick_ff <= (cnt_ff == last_count(sel_i));
         cnt_ff  <= (cnt_ff == last_count(sel_i)) ? '0 : cnt_ff + 1'b1;
      end
      else
         tick_ff <= 1'b0;
   end

   assign tick_o = tick_ff;
endmodule
`default_nettype wire

// >>> src/scdc_core_end.sv
// core end: register access from software and program fetch sequencing
`default_nettype none
module scdc_core_end #(
   parameter int PC_W = 16
) (
   // clock and reset
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   // link to the clock control
   scdc_if.core                  bus,
   // software register port
   input  wire logic [7:0]       sw_addr_i,
   input  wire logic [7:0]       sw_wdata_i,
   input  wire logic             sw_wr_i,
   input  wire logic             sw_rd_i,
   output logic [7:0]            sw_rdata_o,
   // program memory
   input  wire logic [7:0]       code_i,
   input  wire logic             need_byte_i,
   output logic [PC_W-1:0]       pc_o,
   output logic                  fetch_o,
   output logic                  opcode_latch_o,
   output logic [7:0]            opcode_o,
   output logic [7:0]            operand_o,
   output logic                  insn_done_o,
   output logic                  timer_count_en_o
);
   logic [PC_W-1:0] pc_ff;
   logic            fetch_ff;
   logic            latch_ff;
   logic [7:0]      opcode_ff;
   logic [7:0]      operand_ff;
   logic            busy_ff;
   logic            done_ff;
   logic            timer_en_ff;
   logic            cyc_start;
   logic            second;

   // reserved bits forced to zero, holes written only with zero
   assign bus.sfr_addr  = sw_addr_i;
   assign bus.sfr_wr    = sw_wr_i;
   assign bus.sfr_rd    = sw_rd_i;
   assign bus.sfr_wdata = (sw_addr_i == scdc_pkg::SCS_OFFSET) ? (sw_wdata_i & ~scdc_pkg::RSVD_MASK)
                                                              : 8'h00;
   assign sw_rdata_o    = bus.sfr_rdata;

   assign cyc_start = bus.phase_tick && bus.state == scdc_pkg::ST_S1 && bus.phase == scdc_pkg::PH_1;
   assign second    = bus.phase_tick && bus.state == scdc_pkg::ST_S4 && bus.phase == scdc_pkg::PH_1;

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         fetch_ff <= 1'b0;
         latch_ff <= 1'b0;
      end
      else
      begin
         fetch_ff <= cyc_start || second;
         latch_ff <= cyc_start;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         opcode_ff <= 8'h00;
      else if (cyc_start)
         opcode_ff <= code_i;
   end

   // an unneeded second byte is dropped and the counter holds
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         pc_ff      <= '0;
         operand_ff <= 8'h00;
      end
      else if (cyc_start)
         pc_ff <= pc_ff + 1'b1;
      else if (second && need_byte_i)
      begin
         pc_ff      <= pc_ff + 1'b1;
         operand_ff <= code_i;
      end
   end

   // end of state six is the same edge that opens the next state one
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         busy_ff     <= 1'b0;
         done_ff     <= 1'b0;
         timer_en_ff <= 1'b0;
      end
      else
      begin
         busy_ff     <= busy_ff || cyc_start;
         done_ff     <= cyc_start && busy_ff;
         timer_en_ff <= cyc_start;
      end
   end

   assign pc_o             = pc_ff;
   assign fetch_o          = fetch_ff;
   assign opcode_latch_o   = latch_ff;
   assign opcode_o         = opcode_ff;
   assign operand_o        = operand_ff;
   assign insn_done_o      = done_ff;
   assign timer_count_en_o = timer_en_ff;
endmodule
`default_nettype wire

// >>> tb/scdc_sva.sv
// assertions on the link between the clock control end and the core end
`default_nettype none
module scdc_sva (
   // clock and reset
   input wire logic                  mclk_i,
   input wire logic                  rst_i,
   // link signals
   input wire logic [7:0]            sfr_addr,
   input wire logic [7:0]            sfr_wdata,
   input wire logic                  sfr_wr,
   input wire logic                  sfr_rd,
   input wire logic [7:0]            sfr_rdata,
   input var  scdc_pkg::scdc_state_t state,
   input var  scdc_pkg::scdc_phase_t phase,
   input wire logic                  phase_tick
);
   logic [4:0] cfg_ff;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // mirror of the select register as written over the link
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         cfg_ff <= 5'h00;
      else if (sfr_wr && sfr_addr == 8'h80)
         cfg_ff <= sfr_wdata[4:0];
   end
   wr_mask_a: assert property (
      sfr_wr && sfr_addr == 8'h80 |-> sfr_wdata[7:5] == 3'h0) else $error("reserved bits sent");
   hole_wr_a: assert property (
      sfr_wr && sfr_addr != 8'h80 |-> sfr_wdata == 8'h00) else $error("ones sent to hole");
   hole_rd_a: assert property (
      sfr_rd && sfr_addr != 8'h80 && sfr_addr != 8'h8e |=> sfr_rdata == 8'h00) else $error("hole read");
   sel_readback_a: assert property (
      sfr_rd && sfr_addr == 8'h80 |=> sfr_rdata == {3'h0, cfg_ff}) else $error("select readback");
   status_state_a: assert property (
      sfr_rd && sfr_addr == 8'h8e |=> sfr_rdata[2:0] == 3'($past(state))) else $error("status state");
   state_step_a: assert property (
      phase_tick && phase == scdc_pkg::PH_1 |-> (($past(state) == scdc_pkg::ST_S6) ? state == scdc_pkg::ST_S1
         : 3'(state) == 3'($past(state)) + 3'h1)) else $error("state order");
   phase_flip_a: assert property (
      phase_tick |-> phase != $past(phase)) else $error("phase order");
   phase_two_a: assert property (
      phase_tick && phase == scdc_pkg::PH_2 |-> state == $past(state)) else $error("state moved in phase two");
   tick_hold_a: assert property (
      !phase_tick |-> $stable(state) && $stable(phase)) else $error("state moved without tick");
   tick_pulse_a: assert property (
      phase_tick |=> !phase_tick) else $error("short phase");
endmodule
`default_nettype wire

// >>> tb/tb.sv
// bench joining the clock control end and the core end
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // small oscillator periods keep the run short
   localparam int MC = 2;
   localparam int SC = 5;
   typedef struct packed {logic [7:0] d; logic [7:0] m;} scdc_rd_t;
   typedef struct packed {logic [31:0] len; logic [15:0] pcd; logic [7:0] opc; logic [7:0] opd;} scdc_cyc_t;
   logic        mclk_i = 1'b0, rst_i = 1'b1, sw_wr_i = 1'b0, sw_rd_i = 1'b0, need_byte_i = 1'b0, rd_seen = 1'b0;
   logic        fetch_o, main_osc_run_o, sub_active_o, s1_in;
   logic        sys_clk_o, opcode_latch_o, insn_done_o, timer_count_en_o, sclk_d = 1'b0;
   logic [7:0]  sw_addr_i = 8'h00, sw_wdata_i = 8'h00, code_i = 8'h00, last_code = 8'h00, last_opd = 8'h00;
   logic [7:0]  sw_rdata_o, opcode_o, operand_o;
   logic [15:0] pc_o, pc_start = 16'h0000, lfsr = 16'h226a;
   logic [2:0]  sels [6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
   int          cyc_len = 0, fetches = 0, fail_count = 0, checked = 0, nt = 0;
   int          rises = 0, highs = 0, latches = 0, dones = 0, tmrs = 0;
   scdc_rd_t    rd_q[$];
   scdc_cyc_t   cyc_q[$];

   scdc_if lnk ();
   scdc_dev_end #(.MAIN_CYC(MC), .SUB_CYC(SC)) u_scdc_dev_end (.mclk_i(mclk_i), .rst_i(rst_i), .bus(lnk.dev),
      .main_osc_run_o(main_osc_run_o), .sub_active_o(sub_active_o), .sys_clk_o(sys_clk_o));
   scdc_core_end u_scdc_core_end (.mclk_i(mclk_i), .rst_i(rst_i), .bus(lnk.core), .sw_addr_i(sw_addr_i),
      .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o), .code_i(code_i),
      .need_byte_i(need_byte_i), .pc_o(pc_o), .fetch_o(fetch_o), .opcode_latch_o(opcode_latch_o),
      .opcode_o(opcode_o), .operand_o(operand_o), .insn_done_o(insn_done_o),
      .timer_count_en_o(timer_count_en_o));
   scdc_sva u_scdc_sva (.mclk_i(mclk_i), .rst_i(rst_i), .sfr_addr(lnk.sfr_addr), .sfr_wdata(lnk.sfr_wdata),
      .sfr_wr(lnk.sfr_wr), .sfr_rd(lnk.sfr_rd), .sfr_rdata(lnk.sfr_rdata), .state(lnk.state), .phase(lnk.phase),
      .phase_tick(lnk.phase_tick));
   assign s1_in = lnk.phase_tick && lnk.state == scdc_pkg::ST_S1 && lnk.phase == scdc_pkg::PH_1;
   always #5 mclk_i = ~mclk_i;

   function automatic logic [15:0] lfsr_step(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic cmp_rd(input scdc_rd_t e, input logic [7:0] g);
      chk("read data", e.d & e.m, g & e.m);
   endtask
   task automatic cmp_cyc(input scdc_cyc_t e);
      chk("cycle length", e.len, cyc_len);
      chk("fetch count", 2, fetches);
      chk("pc step", e.pcd, 16'(pc_o - pc_start));
      chk("opcode", e.opc, opcode_o);
      chk("operand", e.opd, operand_o);
      chk("sys clock rises", 6, rises);
      chk("sys clock high", e.len / 2, highs);
      chk("opcode latches", 1, latches);
      chk("insn done", 1, dones);
      chk("timer enables", 1, tmrs);
   endtask
   // strobes are never lowered at the end of a task, so back to back calls assign once
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sw_addr_i <= a;
      sw_wdata_i <= d;
      sw_wr_i <= 1'b1;
      sw_rd_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
      sw_addr_i <= a;
      sw_rd_i <= 1'b1;
      sw_wr_i <= 1'b0;
      rd_q.push_back({d, m});
      @(posedge mclk_i);
   endtask
   task automatic idle();
      sw_wr_i <= 1'b0;
      sw_rd_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic wait_s1();
      int k;
      k = 0;
      @(posedge mclk_i);
      while (s1_in !== 1'b1 && k < 4000)
      begin
         @(posedge mclk_i);
         k++;
      end
      if (k >= 4000)
      begin
         fail_count++;
         give_verdict();
      end
   endtask
   // first cycle after a change may be stretched by arming, so skip it
   task automatic meas(input int n);
      logic [7:0] v;
      logic       nb;
      wait_s1();
      wait_s1();
      lfsr = lfsr_step(lfsr);
      v = lfsr[7:0];
      nb = lfsr[8];
      code_i <= v;
      need_byte_i <= nb;
      @(posedge mclk_i);
      cyc_q.push_back({32'(12 * n), 16'(1 + nb), last_code, nb ? v : last_opd});
      last_code = v;
      if (nb)
         last_opd = v;
      wait_s1();
   endtask

   always @(posedge mclk_i)
   begin
      rd_seen <= sw_rd_i;
      cyc_len++;
      fetches += (fetch_o === 1'b1);
      rises += (sys_clk_o === 1'b1 && sclk_d === 1'b0);
      highs += (sys_clk_o === 1'b1);
      latches += (opcode_latch_o === 1'b1);
      dones += (insn_done_o === 1'b1);
      tmrs += (timer_count_en_o === 1'b1);
      sclk_d <= sys_clk_o;
      if (rd_seen && rd_q.size() > 0)
         cmp_rd(rd_q.pop_front(), sw_rdata_o);
      if (s1_in === 1'b1)
      begin
         if (cyc_q.size() > 0)
            cmp_cyc(cyc_q.pop_front());
         cyc_len = 0;
         fetches = 0;
         rises = 0;
         highs = 0;
         latches = 0;
         dones = 0;
         tmrs = 0;
         pc_start = pc_o;
      end
   end

   initial
   begin
      repeat (6) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      rd(8'h80, 8'h00, 8'hff);
      idle();
      chk("main run", 1, main_osc_run_o);
      chk("sub active", 0, sub_active_o);
      $display("test reset done");
      for (int i = 0; i < 6; i++)
      begin
         lfsr = lfsr_step(lfsr);
         wr(8'h80, 8'he0 | {5'h00, sels[i]});
         wr(8'h81 + {5'h00, lfsr[2:0]}, 8'hff);
         rd(8'h80, {5'h00, sels[i]}, 8'hff);
         rd(8'h90 + {5'h00, lfsr[5:3]}, scdc_pkg::RDATA_IDLE, 8'hff);
         idle();
         meas(MC << (sels[i][2] ? sels[i][1:0] + 1 : 0));
         rd(8'h8e, {2'b10, sels[i], 3'b000}, 8'hf8);
         idle();
      end
      $display("test divider done");
      wr(8'h80, 8'h10);
      idle();
      repeat (400) @(posedge mclk_i);
      for (int i = 0; i < 200; i++)
      begin
         @(posedge mclk_i);
         if (lnk.phase_tick === 1'b1)
            nt++;
      end
      chk("halt ticks", 0, nt);
      chk("main run", 0, main_osc_run_o);
      wr(8'h80, 8'h18);
      idle();
      meas(SC);
      chk("sub active", 1, sub_active_o);
      rd(8'h8e, 8'h40, 8'hf8);
      idle();
      $display("test oscillators done");
      rst_i <= 1'b1;
      need_byte_i <= 1'b0;
      last_opd = 8'h00;
      repeat (3) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      rd(8'h80, 8'h00, 8'hff);
      idle();
      meas(MC);
      $display("test second reset done");
      give_verdict();
   end
endmodule
`default_nettype wire
